// ---- common/dadc_pkg.sv ----
// constants shared by the dual converter encode and output mode control
package dadc_pkg;
   // sample word width of each channel
   localparam int unsigned DATA_W = 14;

   // register byte offsets on the ahb-lite slave (low address bits)
   localparam int unsigned REG_AW        = 12;
   localparam logic [11:0] CLK_CTL_OFS   = 12'h000;
   localparam logic [11:0] OUT_MODE_OFS  = 12'h004;
   localparam logic [11:0] STATUS_OFS    = 12'h008;
   localparam logic [11:0] PERIOD_OFS    = 12'h00C;

   // field positions
   localparam int unsigned CLK_CTL_DCS_BIT = 0;
   localparam int unsigned OUT_MODE_LSB    = 0;
   localparam int unsigned ST_NAP_BIT      = 0;
   localparam int unsigned ST_SE_BIT       = 1;
   localparam int unsigned ST_LOCK_BIT     = 2;
   localparam int unsigned ST_PAR_BIT      = 3;
   localparam int unsigned ST_MODE_LSB     = 4;
   localparam int unsigned ST_WARN_BIT     = 6;
   localparam int unsigned ST_VALID_BIT    = 7;

   // reset values
   localparam logic       CLK_CTL_RST  = 1'b0;
   localparam logic [1:0] OUT_MODE_RST = 2'h0;

   // digital output mode encodings
   localparam logic [1:0] MODE_FULL_CMOS = 2'h0;
   localparam logic [1:0] MODE_DDR_CMOS  = 2'h1;
   localparam logic [1:0] MODE_DDR_LVDS  = 2'h2;

   // timing: core clock rate, thresholds derived from it, and fixed cycle counts and widths
   localparam int unsigned CORE_CLK_KHZ     = 100000;
   localparam int unsigned NAP_FREQ_KHZ     = 500;
   localparam int unsigned NAP_CYCLES       = CORE_CLK_KHZ / NAP_FREQ_KHZ;
   localparam int unsigned DCS_MIN_RATE_KHZ = 5000;
   localparam int unsigned DCS_MIN_PER_CYC  = CORE_CLK_KHZ / DCS_MIN_RATE_KHZ;
   localparam int unsigned DCS_LOCK_CYCLES  = 100;
   localparam int unsigned FREQ_TOL_CYCLES  = 2;
   localparam int unsigned CNT_W            = 8;
endpackage

// ---- hdl/dadc_ctl.sv ----
// dual converter encode detection, nap, stabilizer lock and output modes
//
// Overview of operation
// - two channels of fourteen-bit samples are handled
// - both channels captured on one encode edge
// - low negative encode input selects single-ended mode
// - stopped or slow encode clock enters nap
// - stabilizer duty correction is analog; logic only tracks its lock
// - stabilizer lock needs one hundred encode cycles
// - stabilizer enable from register or chip-select pin
// - three output modes: cmos, ddr cmos, ddr lvds
// - output mode from register or serial clock pin
// - parallel programming cannot choose ddr cmos
// - full rate drives words, overflows, clock pair
// - conversion begins on the encode rising edge
// - full rate data change on output clock fall
// - parallel mode uses serial clock pin as selector
module dadc_ctl
   import dadc_pkg::*;
(
   // core clock and reset
   input  wire logic                        CORE_CLK,
   input  wire logic                        ARST_N,
   // ahb-lite register slave
   input  wire logic                        HSEL,
   input  wire logic [31:0]                 HADDR,
   input  wire logic [1:0]                  HTRANS,
   input  wire logic                        HWRITE,
   input  wire logic [2:0]                  HSIZE,
   input  wire logic [31:0]                 HWDATA,
   input  wire logic                        HREADY,
   output logic      [31:0]                 HRDATA,
   output logic                             HREADYOUT,
   output logic                             HRESP,
   // encode link and converter core samples
   input  wire logic                        ENC_CLK,
   input  wire logic                        ENC_NEG_ABOVE_GND,
   input  wire logic [dadc_pkg::DATA_W-1:0] CH1_SAMPLE,
   input  wire logic [dadc_pkg::DATA_W-1:0] CH2_SAMPLE,
   input  wire logic                        CH1_OVR,
   input  wire logic                        CH2_OVR,
   // strap pins
   input  wire logic                        PROG_MODE_SELECT,
   input  wire logic                        PAR_DCS_SEL,
   input  wire logic                        PAR_MODE_SEL,
   // digital outputs
   output logic      [dadc_pkg::DATA_W-1:0] CH1_DATA_BITS,
   output logic      [dadc_pkg::DATA_W-1:0] CH2_DATA_BITS,
   output logic                             OVERFLOW_CH1,
   output logic                             OVERFLOW_CH2,
   output logic                             DATA_OUT_CLK_POS,
   output logic                             DATA_OUT_CLK_NEG,
   output logic                             LVDS_DRIVE,
   // status
   output logic                             NAP_ACTIVE,
   output logic                             SINGLE_ENDED_MODE,
   output logic                             DCS_LOCKED,
   output logic                             SAMPLE_VALID
);
   import dadc_pkg::*;

   localparam int unsigned PIN_NEG  = 0;
   localparam int unsigned PIN_PAR  = 1;
   localparam int unsigned PIN_DCS  = 2;
   localparam int unsigned PIN_MODE = 3;
   localparam logic [CNT_W-1:0] NAP_LIMIT = CNT_W'(NAP_CYCLES - 1);
   localparam logic [CNT_W-1:0] NAP_SAT   = CNT_W'(NAP_CYCLES);
   localparam logic [CNT_W-1:0] LOCK_N    = CNT_W'(DCS_LOCK_CYCLES);
   localparam logic [CNT_W-1:0] TOL_N     = CNT_W'(FREQ_TOL_CYCLES);
   localparam logic [CNT_W-1:0] MIN_PER_N = CNT_W'(DCS_MIN_PER_CYC);

   // one ddr phase of a word: bit pair i sits on pin i
   function automatic logic [DATA_W-1:0] ddr_pack(
      input logic [DATA_W-1:0] word,
      input logic              odd);
      logic [DATA_W-1:0] r;
      r = '0;
      for (int i = 0; i < DATA_W / 2; i++) begin
         r[i] = odd ? word[2*i+1] : word[2*i];
      end
      return r;
   endfunction

   // register read mux shared by the address phase
   logic [CNT_W-1:0] per_meas_q;
   logic             clk_ctl_q;
   logic [1:0]       out_mode_q;
   logic [7:0]       status_w;

   function automatic logic [31:0] rd_mux(input logic [REG_AW-1:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (a == CLK_CTL_OFS) begin
         r[CLK_CTL_DCS_BIT] = clk_ctl_q;
      end else if (a == OUT_MODE_OFS) begin
         r[OUT_MODE_LSB +: 2] = out_mode_q;
      end else if (a == STATUS_OFS) begin
         r[7:0] = status_w;
      end else if (a == PERIOD_OFS) begin
         r[CNT_W-1:0] = per_meas_q;
      end
      return r;
   endfunction

   // ---------------- core domain ----------------

   // strap and comparator pins pass two flops before use
   logic [3:0] pin_s1_q;
   logic [3:0] pin_s2_q;
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         // negative input idles above ground: no false single-ended pulse
         pin_s1_q <= 4'h1;
         pin_s2_q <= 4'h1;
      end else begin
         pin_s1_q <= {PAR_MODE_SEL, PAR_DCS_SEL, PROG_MODE_SELECT,
                      ENC_NEG_ABOVE_GND};
         pin_s2_q <= pin_s1_q;
      end
   end

   // encode edges arrive as a toggle; s3 only serves the edge detect
   logic rise_tgl_q;
   logic tgl_s1_q;
   logic tgl_s2_q;
   logic tgl_s3_q;
   logic enc_edge;
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         tgl_s3_q <= 1'b0;
      end else begin
         tgl_s1_q <= rise_tgl_q;
         tgl_s2_q <= tgl_s1_q;
         tgl_s3_q <= tgl_s2_q;
      end
   end
   assign enc_edge = tgl_s2_q ^ tgl_s3_q;

   // encode period in core cycles, saturating at the nap threshold
   logic [CNT_W-1:0] per_cnt_q;
   logic [CNT_W-1:0] per_new;
   logic [CNT_W-1:0] per_diff;
   logic             freq_chg;
   assign per_new  = CNT_W'(per_cnt_q + 1'b1);
   assign per_diff = (per_new > per_meas_q) ? CNT_W'(per_new - per_meas_q)
                                            : CNT_W'(per_meas_q - per_new);
   // one core cycle of jitter is normal at these rates, so allow a margin
   assign freq_chg = enc_edge && (per_diff > TOL_N);

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         per_cnt_q  <= '0;
         per_meas_q <= '0;
      end else if (enc_edge) begin
         per_cnt_q  <= '0;
         per_meas_q <= per_new;
      end else if (per_cnt_q != NAP_SAT) begin
         per_cnt_q  <= per_new;
      end
   end

   // nap: entered on a long gap, left only after a short period is seen
   logic nap_q;
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         nap_q <= 1'b1;
      end else if (enc_edge || per_cnt_q >= NAP_LIMIT) begin
         nap_q <= (per_cnt_q >= NAP_LIMIT);
      end
   end

   // single-ended mode when the negative input sits near ground
   logic se_q;
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         se_q <= 1'b0;
      end else begin
         se_q <= !pin_s2_q[PIN_NEG];
      end
   end

   // effective stabilizer enable and output mode from register or straps
   logic       par_q;
   logic       eff_dcs_q;
   logic [1:0] eff_mode_q;
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         par_q      <= 1'b0;
         eff_dcs_q  <= CLK_CTL_RST;
         eff_mode_q <= OUT_MODE_RST;
      end else begin
         par_q <= pin_s2_q[PIN_PAR];
         if (pin_s2_q[PIN_PAR]) begin
            eff_dcs_q  <= pin_s2_q[PIN_DCS];
            // only two choices exist on the strap pin
            eff_mode_q <= pin_s2_q[PIN_MODE] ? MODE_DDR_LVDS
                                             : MODE_FULL_CMOS;
         end else begin
            eff_dcs_q  <= clk_ctl_q;
            // the spare code falls back to full rate cmos
            eff_mode_q <= (out_mode_q == 2'h3) ? MODE_FULL_CMOS
                                               : out_mode_q;
         end
      end
   end

   // stabilizer lock: duty correction itself is analog, logic tracks lock
   logic [CNT_W-1:0] lock_cnt_q;
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         lock_cnt_q <= '0;
      end else if (!eff_dcs_q || nap_q || freq_chg) begin
         lock_cnt_q <= '0;
      end else if (enc_edge && lock_cnt_q != LOCK_N) begin
         lock_cnt_q <= CNT_W'(lock_cnt_q + 1'b1);
      end
   end

   // status flops; samples are flagged invalid in nap and, with the stabilizer on, before lock
   logic dcs_locked_q;
   logic valid_q;
   logic warn_q;
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         dcs_locked_q <= 1'b0;
         valid_q      <= 1'b0;
         warn_q       <= 1'b0;
      end else begin
         dcs_locked_q <= (lock_cnt_q == LOCK_N);
         valid_q      <= !nap_q && (!eff_dcs_q || lock_cnt_q == LOCK_N);
         // hint to software that the stabilizer runs too slow a clock
         warn_q       <= eff_dcs_q && (per_meas_q > MIN_PER_N);
      end
   end
   assign status_w = {valid_q, warn_q, eff_mode_q, par_q, dcs_locked_q,
                      se_q, nap_q};

   // ahb-lite slave: zero wait states, read data prepared in address phase
   logic              take;
   logic              dp_wr_q;
   logic [REG_AW-1:0] dp_addr_q;
   logic [31:0]       rdata_q;
   assign take = HSEL && HREADY && HTRANS[1];
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         dp_wr_q   <= 1'b0;
         dp_addr_q <= '0;
         rdata_q   <= 32'h0000_0000;
      end else begin
         dp_wr_q   <= take && HWRITE && (HSIZE == 3'h2);
         dp_addr_q <= HADDR[REG_AW-1:0];
         rdata_q   <= (take && !HWRITE) ? rd_mux(HADDR[REG_AW-1:0])
                                        : 32'h0000_0000;
      end
   end

   // register writes land in the data phase; unmapped writes are dropped
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         clk_ctl_q  <= CLK_CTL_RST;
         out_mode_q <= OUT_MODE_RST;
      end else if (dp_wr_q) begin
         if (dp_addr_q == CLK_CTL_OFS) begin
            clk_ctl_q <= HWDATA[CLK_CTL_DCS_BIT];
         end else if (dp_addr_q == OUT_MODE_OFS) begin
            out_mode_q <= HWDATA[OUT_MODE_LSB +: 2];
         end
      end
   end

   assign HRDATA            = rdata_q;
   assign HREADYOUT         = 1'b1;
   assign HRESP             = 1'b0;
   assign NAP_ACTIVE        = nap_q;
   assign SINGLE_ENDED_MODE = se_q;
   assign DCS_LOCKED        = dcs_locked_q;
   assign SAMPLE_VALID      = valid_q;

   // ---------------- encode domain ----------------

   // output mode is quasi-static; a change may show one mixed word
   logic [1:0]        mode_s1_q;
   logic [1:0]        mode_s2_q;
   logic [1:0]        mode_s3_q;
   logic [1:0]        mode_q;
   logic [DATA_W-1:0] s1_q;
   logic [DATA_W-1:0] s2_q;
   logic              o1_q;
   logic              o2_q;
   always_ff @(posedge ENC_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mode_s1_q  <= OUT_MODE_RST;
         mode_s2_q  <= OUT_MODE_RST;
         mode_s3_q  <= OUT_MODE_RST;
         mode_q     <= OUT_MODE_RST;
         s1_q       <= '0;
         s2_q       <= '0;
         o1_q       <= 1'b0;
         o2_q       <= 1'b0;
         rise_tgl_q <= 1'b0;
      end else begin
         mode_s1_q  <= eff_mode_q;
         mode_s2_q  <= mode_s1_q;
         mode_s3_q  <= mode_s2_q;
         // two equal samples in a row: a half-changed code never acts
         if (mode_s2_q == mode_s3_q) begin
            mode_q <= mode_s3_q;
         end
         // one edge samples both channels together
         s1_q       <= CH1_SAMPLE;
         s2_q       <= CH2_SAMPLE;
         o1_q       <= CH1_OVR;
         o2_q       <= CH2_OVR;
         rise_tgl_q <= ~rise_tgl_q;
      end
   end

   // launch words on the falling edge so the receiver latches on rise
   logic [DATA_W-1:0] w1_q;
   logic [DATA_W-1:0] w2_q;
   logic              wo1_q;
   logic              wo2_q;
   logic              fall_tgl_q;
   always_ff @(negedge ENC_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         w1_q       <= '0;
         w2_q       <= '0;
         wo1_q      <= 1'b0;
         wo2_q      <= 1'b0;
         fall_tgl_q <= 1'b0;
      end else begin
         w1_q       <= s1_q;
         w2_q       <= s2_q;
         wo1_q      <= o1_q;
         wo2_q      <= o2_q;
         fall_tgl_q <= rise_tgl_q;
      end
   end

   // output clock is high between rise and fall; two toggles avoid a
   // flop clocked on both edges at the price of an xor on the pin
   logic clk_high;
   logic full_mode;
   assign clk_high  = rise_tgl_q ^ fall_tgl_q;
   assign full_mode = (mode_q == MODE_FULL_CMOS);

   // ddr modes: even bits while clock low, odd bits while high
   assign CH1_DATA_BITS    = full_mode ? w1_q : ddr_pack(w1_q, clk_high);
   assign CH2_DATA_BITS    = full_mode ? w2_q : ddr_pack(w2_q, clk_high);
   // ddr shares one overflow pin: channel 2 low, channel 1 high
   assign OVERFLOW_CH1     = full_mode ? wo1_q : (clk_high ? wo1_q : wo2_q);
   assign OVERFLOW_CH2     = full_mode ? wo2_q : 1'b0;
   assign DATA_OUT_CLK_POS = clk_high;
   assign DATA_OUT_CLK_NEG = !clk_high;
   assign LVDS_DRIVE       = (mode_q == MODE_DDR_LVDS);

   // ---------------- checks ----------------

   property p_nap_entry;
      @(posedge CORE_CLK) disable iff (!ARST_N)
         (per_cnt_q >= NAP_LIMIT) |=> nap_q;
   endproperty
   a_nap_entry: assert property (p_nap_entry)
      else $error("nap not entered after long encode gap");

   property p_single_ended;
      @(posedge CORE_CLK) disable iff (!ARST_N)
         $fell(pin_s2_q[PIN_NEG]) |=> se_q;
   endproperty
   a_single_ended: assert property (p_single_ended)
      else $error("single-ended mode not detected");

   property p_lock_restart;
      @(posedge CORE_CLK) disable iff (!ARST_N)
         freq_chg |-> ##2 !dcs_locked_q;
   endproperty
   a_lock_restart: assert property (p_lock_restart)
      else $error("lock kept across frequency change");

   property p_lock_count;
      @(posedge CORE_CLK) disable iff (!ARST_N)
         $rose(dcs_locked_q) |-> $past(lock_cnt_q) == LOCK_N && eff_dcs_q;
   endproperty
   a_lock_count: assert property (p_lock_count)
      else $error("lock declared before one hundred cycles");

   property p_dcs_par;
      @(posedge CORE_CLK) disable iff (!ARST_N)
         pin_s2_q[PIN_PAR] |=> eff_dcs_q == $past(pin_s2_q[PIN_DCS]);
   endproperty
   a_dcs_par: assert property (p_dcs_par)
      else $error("stabilizer enable not taken from strap");

   property p_mode_ser;
      @(posedge CORE_CLK) disable iff (!ARST_N)
         !pin_s2_q[PIN_PAR] && out_mode_q != 2'h3
         |=> eff_mode_q == $past(out_mode_q);
   endproperty
   a_mode_ser: assert property (p_mode_ser)
      else $error("output mode not taken from register");

   property p_par_no_ddr;
      @(posedge CORE_CLK) disable iff (!ARST_N)
         par_q |-> eff_mode_q != MODE_DDR_CMOS;
   endproperty
   a_par_no_ddr: assert property (p_par_no_ddr)
      else $error("ddr cmos chosen in parallel mode");

   property p_par_lvds;
      @(posedge CORE_CLK) disable iff (!ARST_N)
         pin_s2_q[PIN_PAR] && pin_s2_q[PIN_MODE]
         |=> eff_mode_q == MODE_DDR_LVDS;
   endproperty
   a_par_lvds: assert property (p_par_lvds)
      else $error("strap did not select lvds");

   property p_same_instant;
      @(posedge ENC_CLK) disable iff (!ARST_N)
         1'b1 |=> {s1_q, s2_q} == $past({CH1_SAMPLE, CH2_SAMPLE});
   endproperty
   a_same_instant: assert property (p_same_instant)
      else $error("channels not sampled on one edge");

   property p_fall_launch;
      @(negedge ENC_CLK) disable iff (!ARST_N)
         full_mode && DATA_OUT_CLK_POS |-> CH1_DATA_BITS == $past(s1_q);
   endproperty
   a_fall_launch: assert property (p_fall_launch)
      else $error("full rate word not launched with clock low");
endmodule

// ---- tb/dadc_rx_model.sv ----
// capture receiver model for the converter digital outputs
module dadc_rx_model
   import dadc_pkg::*;
(
   // receiver controls
   input  wire logic                        enable,
   input  wire logic                        ddr,
   // converter outputs
   input  wire logic                        clk_pos,
   input  wire logic                        valid,
   input  wire logic [dadc_pkg::DATA_W-1:0] d1,
   input  wire logic [dadc_pkg::DATA_W-1:0] d2,
   input  wire logic                        of1,
   input  wire logic                        of2,
   // tallies
   output int                               errs,
   output int                               words
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [DATA_W-1:0] e1, e2, w1, w2, prv;
   logic              eo, have_e, have_p;

   // rebuild one word from its even and odd phase bits
   function automatic logic [DATA_W-1:0] join_w(
      input logic [DATA_W-1:0] ev, od);
      logic [DATA_W-1:0] w;
      for (int i = 0; i < DATA_W / 2; i++) begin
         w[2*i]   = ev[i];
         w[2*i+1] = od[i];
      end
      return w;
   endfunction

   // judge one word pair; ok carries the overflow verdict
   task automatic take(input logic ok);
      if (w2 !== ~w1 || !ok || (have_p && w1 !== prv + 1'b1)) begin
         errs++;
      end
      prv    = w1;
      have_p = 1'b1;
      words++;
   endtask

   initial begin
      errs   = 0;
      words  = 0;
      have_e = 1'b0;
      have_p = 1'b0;
   end

   // look mid-phase, well clear of the output transitions
   always @(clk_pos) begin
      #3;
      if (!enable || valid !== 1'b1) begin
         have_e = 1'b0;
         have_p = 1'b0;
      end else if (!ddr) begin
         if (clk_pos) begin
            w1 = d1;
            w2 = d2;
            take(of1 === d1[0] && of2 === ~d1[0]);
         end
      end else if (!clk_pos) begin
         // low phase: even bits and the second channel's overflow
         e1     = d1;
         e2     = d2;
         eo     = (of1 === ~d1[0]) && (of2 === 1'b0);
         have_e = 1'b1;
      end else if (have_e) begin
         w1 = join_w(e1, d1);
         w2 = join_w(e2, d2);
         take(eo && of1 === w1[0] && of2 === 1'b0);
      end
   end
endmodule

// ---- tb/dadc_ctl_bench.sv ----
// self-checking bench for the encode and output mode control
module dadc_ctl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import dadc_pkg::*;
   logic              clk = 1'b0, rst_n = 1'b0, sel = 1'b0, wr = 1'b0;
   logic              enc = 1'b0, enc_run = 1'b1, neg_ok = 1'b1;
   logic              par = 1'b0, p_dcs = 1'b0, p_mode = 1'b0;
   logic              rx_en = 1'b0, rx_ddr = 1'b0, rdy, hresp;
   logic [1:0]        trans = 2'h0, md, em;
   logic [2:0]        size = 3'h2;
   logic [31:0]       addr = 32'h0, wdat = 32'h0, rdat, rd;
   logic [DATA_W-1:0] smp = 14'h0000, d1, d2;
   logic              of1, of2, cp, cn, lvds, nap, se, lck, vld;
   real               enc_half = 7.5;
   int                failures = 0, total_checks = 0, errs, words, w0;

   // core clock, and an encode clock whose edges never meet it
   always #5 clk = ~clk;
   initial begin
      #1.3;
      forever begin
         #(enc_half);
         if (enc_run) begin
            enc = ~enc;
         end
      end
   end
   // converter core words: a count, with its complement on channel 2
   always @(posedge enc) smp <= smp + 14'h0001;

   dadc_ctl dut_u (
      .CORE_CLK(clk), .ARST_N(rst_n), .HSEL(sel), .HADDR(addr),
      .HTRANS(trans), .HWRITE(wr), .HSIZE(size), .HWDATA(wdat),
      .HREADY(rdy), .HRDATA(rdat), .HREADYOUT(rdy), .HRESP(hresp),
      .ENC_CLK(enc), .ENC_NEG_ABOVE_GND(neg_ok), .CH1_SAMPLE(smp),
      .CH2_SAMPLE(~smp), .CH1_OVR(smp[0]), .CH2_OVR(~smp[0]),
      .PROG_MODE_SELECT(par), .PAR_DCS_SEL(p_dcs),
      .PAR_MODE_SEL(p_mode), .CH1_DATA_BITS(d1), .CH2_DATA_BITS(d2),
      .OVERFLOW_CH1(of1), .OVERFLOW_CH2(of2), .DATA_OUT_CLK_POS(cp),
      .DATA_OUT_CLK_NEG(cn), .LVDS_DRIVE(lvds), .NAP_ACTIVE(nap),
      .SINGLE_ENDED_MODE(se), .DCS_LOCKED(lck), .SAMPLE_VALID(vld)
   );

   dadc_rx_model rx_u (
      .enable(rx_en), .ddr(rx_ddr), .clk_pos(cp), .valid(vld),
      .d1(d1), .d2(d2), .of1(of1), .of2(of2),
      .errs(errs), .words(words)
   );

   task automatic stop_test;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // report a difference at once and count every comparison
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one ahb-lite single transfer: address phase, then data phase
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [2:0] s);
      @(posedge clk);
      sel   <= 1'b1;
      trans <= 2'h2;
      wr    <= w;
      addr  <= {20'h00000, a};
      size  <= s;
      do @(posedge clk); while (rdy !== 1'b1);
      sel   <= 1'b0;
      trans <= 2'h0;
      wdat  <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      rd = rdat;
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 3'h2);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0, 3'h2);
      check(rd, e);
   endtask

   // expected status word from its fields
   function automatic logic [31:0] st(input logic n, s, l, p,
      input logic [1:0] m, input logic wn, v);
      logic [31:0] r;
      r = 32'h0;
      r[ST_NAP_BIT] = n;
      r[ST_SE_BIT] = s;
      r[ST_LOCK_BIT] = l;
      r[ST_PAR_BIT] = p;
      r[ST_MODE_LSB +: 2] = m;
      r[ST_WARN_BIT] = wn;
      r[ST_VALID_BIT] = v;
      return r;
   endfunction

   // waits end 1 ns past a core edge so flop outputs have settled
   task automatic wait_enc(input int n);
      repeat (n) @(posedge enc);
      @(posedge clk);
      #1;
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // receiver takes words for 40 encode cycles; mode changes stay outside
   task automatic rx_run(input logic ddr);
      w0     = words;
      rx_ddr = ddr;
      rx_en  = 1'b1;
      wait_enc(40);
      rx_en  = 1'b0;
   endtask

   // watchdog: the whole sequence needs well under 100 us
   initial begin
      #400000;
      failures++;
      stop_test;
   end

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      wait_clk(40);
      rd_chk(CLK_CTL_OFS, 32'h0);
      rd_chk(OUT_MODE_OFS, 32'h0);
      rd_chk(STATUS_OFS, st(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1));
      rd_chk(12'h010, 32'h0);
      // every mode code; code 3 reads back but acts as full rate
      for (int m = 0; m < 4; m++) begin
         md = 2'(m);
         em = (md == 2'h3) ? MODE_FULL_CMOS : md;
         wr_reg(OUT_MODE_OFS, {30'h0, md});
         rd_chk(OUT_MODE_OFS, {30'h0, md});
         wait_enc(4);
         rd_chk(STATUS_OFS, st(1'b0, 1'b0, 1'b0, 1'b0, em, 1'b0, 1'b1));
         check({31'h0, lvds}, {31'h0, em == MODE_DDR_LVDS});
         check({30'h0, cn, hresp}, {30'h0, ~cp, 1'b0});
         rx_run(em != MODE_FULL_CMOS);
         check(32'(errs), 32'h0);
         check({31'h0, words - w0 > 30}, 32'h1);
      end
      // a byte-wide write is refused and leaves the mode alone
      xfer(1'b1, OUT_MODE_OFS, 32'h2, 3'h0);
      rd_chk(OUT_MODE_OFS, 32'h3);
      wr_reg(OUT_MODE_OFS, 32'h0);
      // grounded negative encode input means single-ended encode
      @(posedge clk) neg_ok <= 1'b0;
      wait_clk(8);
      rd_chk(STATUS_OFS, st(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1));
      @(posedge clk) neg_ok <= 1'b1;
      wait_clk(8);
      check({31'h0, se}, 32'h0);
      // stopped encode clock: nap, then wake on restart
      enc_run = 1'b0;
      wait_clk(230);
      check({30'h0, nap, vld}, 32'h2);
      enc_run = 1'b1;
      wait_clk(30);
      check({30'h0, nap, vld}, 32'h1);
      // stabilizer at 20 Msps: no lock before 100 encode cycles
      enc_half = 25.0;
      wait_enc(10);
      wr_reg(CLK_CTL_OFS, 32'h1);
      rd_chk(CLK_CTL_OFS, 32'h1);
      rd_chk(PERIOD_OFS, 32'h5);
      wait_enc(85);
      check({30'h0, lck, vld}, 32'h0);
      wait_enc(20);
      check({30'h0, lck, vld}, 32'h3);
      enc_half = 50.0;
      wait_enc(3);
      check({30'h0, lck, vld}, 32'h0);
      // below 5 Msps the warning shows, so the host turns it off
      enc_half = 125.0;
      wait_enc(3);
      rd_chk(STATUS_OFS, st(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0));
      wr_reg(CLK_CTL_OFS, 32'h0);
      enc_half = 7.5;
      wait_enc(10);
      // parallel programming: pins rule, ddr cmos unreachable
      wr_reg(OUT_MODE_OFS, {30'h0, MODE_DDR_CMOS});
      @(posedge clk);
      par    <= 1'b1;
      p_mode <= 1'b1;
      p_dcs  <= 1'b1;
      wait_enc(6);
      check({31'h0, lvds}, 32'h1);
      rd_chk(STATUS_OFS, st(1'b0, 1'b0, 1'b0, 1'b1, MODE_DDR_LVDS, 1'b0, 1'b0));
      @(posedge clk) p_mode <= 1'b0;
      wait_enc(6);
      rd_chk(STATUS_OFS, st(1'b0, 1'b0, 1'b0, 1'b1, MODE_FULL_CMOS, 1'b0, 1'b0));
      wait_enc(250);
      check({30'h0, lck, vld}, 32'h3);
      rx_run(1'b0);
      check(32'(errs), 32'h0);
      check({31'h0, words - w0 > 30}, 32'h1);
      stop_test;
   end
endmodule
